// ==== port2_phy_pkg.sv ====
/*
 * Constants for the port 2 transceiver diagnostic and control register bank.
 * Assumes a 16-bit register port, one core clock at 10 MHz, synchronous reset.
 */
package port2_phy_pkg;

    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [7:0] DIAG_OFFSET        = 8'h04;
    localparam logic [7:0] CTRL_OFFSET        = 8'h06;
    localparam logic [7:0] DIAG_MIRROR_OFFSET = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFFSET  = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFFSET    = 8'h22;

    // Diagnostic register field positions
    localparam int GO_BIT     = 15;
    localparam int RESULT_HI  = 14;
    localparam int RESULT_LO  = 13;
    localparam int SHORT_BIT  = 12;
    localparam int COUNT_HI   = 8;
    localparam int COUNT_W    = 9;

    // Special control register field positions
    localparam int POLARITY_BIT       = 5;
    localparam int CROSSOVER_BIT      = 4;
    localparam int FORCE_LINK_BIT     = 3;
    localparam int POWER_SAVE_OFF_BIT = 2;
    localparam int LOOPBACK_BIT       = 1;

    // Outcome codes
    localparam logic [1:0] RESULT_NORMAL = 2'h0;
    localparam logic [1:0] RESULT_OPEN   = 2'h1;
    localparam logic [1:0] RESULT_SHORT  = 2'h2;
    localparam logic [1:0] RESULT_FAILED = 2'h3;

    // Values after reset
    localparam logic [1:0] RESULT_RESET         = 2'h0;
    localparam logic [8:0] COUNT_RESET          = 9'h000;
    localparam logic       SHORT_RESET          = 1'h0;
    localparam logic       FORCE_LINK_RESET     = 1'h0;
    localparam logic       POWER_SAVE_OFF_RESET = 1'h1;
    localparam logic       LOOPBACK_RESET       = 1'h0;

    // Interrupt bits
    localparam int IRQ_W         = 3;
    localparam int IRQ_DONE      = 0;
    localparam int IRQ_POLARITY  = 1;
    localparam int IRQ_CROSSOVER = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // Longest wait for the transceiver to finish a test
    localparam int CLOCK_PERIOD_NS     = 100;
    localparam int DIAG_TIMEOUT_US     = 10000;
    localparam int DIAG_TIMEOUT_CYCLES = DIAG_TIMEOUT_US * 1000 / CLOCK_PERIOD_NS;

    // Test sequencer states
    typedef enum logic {DIAG_IDLE, DIAG_RUN} diag_state_t;

endpackage

// ==== bit_sync.sv ====
/*
 * Two-stage synchroniser for a group of slowly changing levels.
 * Assumes each bit is stable for several clocks around any change.
 */
`timescale 1ns/10ps
module bit_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Levels in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta; // First stage, read only by the second

    // Two flops in series
    always_ff @(posedge clock) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// ==== sticky_bits.sv ====
/*
 * Sticky event flags cleared by writing one; a set beats a clear.
 * Assumes set and clear are one-cycle pulses on the same clock.
 */
`timescale 1ns/10ps
module sticky_bits #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Events and clears
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // Flags
    output logic      [W-1:0] q
);

    // Set has priority over the clear in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= set | (q & ~clr);
        end
    end

endmodule

// ==== cable_diag_regs.sv ====
/*
 * Register bank for the port 2 copper transceiver: cable diagnostic
 * test with outcome, short flag and fault distance, a mirror view,
 * wiring status, link and power controls, and an event interrupt.
 * Assumes the transceiver raises its done level once its result lines
 * are settled and holds it until the run request drops.
 */
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module cable_diag_regs #(
    parameter int DIAG_TIMEOUT_CYCLES = port2_phy_pkg::DIAG_TIMEOUT_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // Diagnostic handshake with the transceiver
    output logic             diag_run,
    input  wire logic        diag_done,
    input  wire logic [1:0]  diag_result,
    input  wire logic        diag_short,
    input  wire logic [8:0]  diag_count,
    // Wiring status from the transceiver
    input  wire logic        polarity_reversed,
    input  wire logic        crossover_state,
    // Controls to the transceiver
    output logic             force_link,
    output logic             power_save_off,
    output logic             near_end_loopback,
    // Interrupt
    output logic             irq
);

    localparam int TMO_W = $clog2(DIAG_TIMEOUT_CYCLES + 1);
    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(DIAG_TIMEOUT_CYCLES - 1);

    // Synchronised transceiver inputs
    logic [14:0] sync_q;
    logic        done_s;     // Done level
    logic [1:0]  result_s;   // Outcome lines
    logic        short_s;    // Near short line
    logic [8:0]  count_s;    // Distance lines
    logic        pol_s;      // Polarity status
    logic        cross_s;    // Wiring status

    // Edge detection history
    logic        done_q;     // Done one cycle ago
    logic        pol_q;      // Polarity one cycle ago
    logic        cross_q;    // Wiring one cycle ago
    logic        done_rise;  // Done has just risen

    // Test sequencer
    port2_phy_pkg::diag_state_t state;
    port2_phy_pkg::diag_state_t next_state;
    logic [TMO_W-1:0] tmo_cnt;  // Cycles spent running
    logic        tmo_hit;    // Wait has run out
    logic        finish;     // Transceiver reported an outcome
    logic        fail;       // Transceiver never answered

    // Latched results
    logic [1:0]  result;     // Outcome code
    logic        near_short; // Short within ten metres
    logic [8:0]  count;      // Fault distance

    // Bus decode
    logic        wr_diag;    // Write to either diagnostic view
    logic        go_req;     // Write asking for a test
    logic        wr_ctrl;    // Write to special control
    logic        wr_mask;    // Write to interrupt mask
    logic [15:0] diag_word;  // Diagnostic register image
    logic [15:0] ctrl_word;  // Special control image
    logic [15:0] next_rdata; // Read mux output

    // Interrupts
    logic [2:0]  irq_event;  // One-cycle event pulses
    logic [2:0]  irq_clr;    // Write-one-to-clear pulses
    logic [2:0]  irq_status; // Sticky flags
    logic [2:0]  irq_mask;   // Enable per flag

    // Bring all transceiver lines into the clock domain
    bit_sync #(
        .W(15)
    ) u_sync (
        .clock(clock),
        .rst  (rst),
        .d    ({diag_done, diag_result, diag_short, diag_count,
                polarity_reversed, crossover_state}),
        .q    (sync_q)
    );

    // Split the synchronised group
    assign done_s   = sync_q[14];
    assign result_s = sync_q[13:12];
    assign short_s  = sync_q[11];
    assign count_s  = sync_q[10:2];
    assign pol_s    = sync_q[1];
    assign cross_s  = sync_q[0];

    // History for edge detection
    always_ff @(posedge clock) begin
        if (rst) begin
            done_q  <= 1'b0;
            pol_q   <= 1'b0;
            cross_q <= 1'b0;
        end else begin
            done_q  <= done_s;
            pol_q   <= pol_s;
            cross_q <= cross_s;
        end
    end

    assign done_rise = done_s & ~done_q;

    // Address decode for writes
    assign wr_diag = wr && (addr == port2_phy_pkg::DIAG_OFFSET ||
                            addr == port2_phy_pkg::DIAG_MIRROR_OFFSET);
    assign go_req  = wr_diag && wdata[port2_phy_pkg::GO_BIT];
    assign wr_ctrl = wr && (addr == port2_phy_pkg::CTRL_OFFSET);
    assign wr_mask = wr && (addr == port2_phy_pkg::IRQ_MASK_OFFSET);

    // Wait limit reached on the last running cycle
    assign tmo_hit = (tmo_cnt == TMO_LAST);

    // Sequencer next state
    always_comb begin
        next_state = state;
        finish     = 1'b0;
        fail       = 1'b0;
        unique case (state)
            port2_phy_pkg::DIAG_IDLE: begin
                // A go write starts a test
                if (go_req) begin
                    next_state = port2_phy_pkg::DIAG_RUN;
                end
            end
            port2_phy_pkg::DIAG_RUN: begin
                // Outcome reported, or give up after the wait
                if (done_rise) begin
                    finish     = 1'b1;
                    next_state = port2_phy_pkg::DIAG_IDLE;
                end else if (tmo_hit) begin
                    fail       = 1'b1;
                    next_state = port2_phy_pkg::DIAG_IDLE;
                end
            end
        endcase
    end

    // Sequencer state and run request; go bit self-clears at the end
    always_ff @(posedge clock) begin
        if (rst) begin
            state    <= port2_phy_pkg::DIAG_IDLE;
            diag_run <= 1'b0;
        end else begin
            state    <= next_state;
            diag_run <= (next_state == port2_phy_pkg::DIAG_RUN);
        end
    end

    // Counts running cycles, restarts with each test
    always_ff @(posedge clock) begin
        if (rst) begin
            tmo_cnt <= '0;
        end else if (state == port2_phy_pkg::DIAG_RUN && !tmo_hit) begin
            tmo_cnt <= tmo_cnt + TMO_W'(1);
        end else if (state == port2_phy_pkg::DIAG_IDLE) begin
            tmo_cnt <= '0;
        end
    end

    // Result capture when a test ends
    always_ff @(posedge clock) begin
        if (rst) begin
            result     <= port2_phy_pkg::RESULT_RESET;
            near_short <= port2_phy_pkg::SHORT_RESET;
            count      <= port2_phy_pkg::COUNT_RESET;
        end else if (finish) begin
            // Transceiver outcome taken as reported
            result     <= result_s;
            near_short <= short_s;
            count      <= count_s;
        end else if (fail) begin
            // No answer: report a failed test
            result     <= port2_phy_pkg::RESULT_FAILED;
            near_short <= 1'b0;
            count      <= port2_phy_pkg::COUNT_RESET;
        end
    end

    // Special control bits; other positions are not stored
    always_ff @(posedge clock) begin
        if (rst) begin
            force_link        <= port2_phy_pkg::FORCE_LINK_RESET;
            power_save_off    <= port2_phy_pkg::POWER_SAVE_OFF_RESET;
            near_end_loopback <= port2_phy_pkg::LOOPBACK_RESET;
        end else if (wr_ctrl) begin
            force_link        <= wdata[port2_phy_pkg::FORCE_LINK_BIT];
            power_save_off    <= wdata[port2_phy_pkg::POWER_SAVE_OFF_BIT];
            near_end_loopback <= wdata[port2_phy_pkg::LOOPBACK_BIT];
        end
    end

    // Diagnostic image, shared by both views
    always_comb begin
        diag_word = 16'h0000; // Reserved bits read zero
        diag_word[port2_phy_pkg::GO_BIT] = (state == port2_phy_pkg::DIAG_RUN);
        diag_word[port2_phy_pkg::RESULT_HI:port2_phy_pkg::RESULT_LO] = result;
        diag_word[port2_phy_pkg::SHORT_BIT] = near_short;
        diag_word[port2_phy_pkg::COUNT_HI:0] = count;
    end

    // Special control image
    always_comb begin
        ctrl_word = 16'h0000; // Reserved bits read zero
        ctrl_word[port2_phy_pkg::POLARITY_BIT]       = pol_s;
        ctrl_word[port2_phy_pkg::CROSSOVER_BIT]      = cross_s;
        ctrl_word[port2_phy_pkg::FORCE_LINK_BIT]     = force_link;
        ctrl_word[port2_phy_pkg::POWER_SAVE_OFF_BIT] = power_save_off;
        ctrl_word[port2_phy_pkg::LOOPBACK_BIT]       = near_end_loopback;
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        unique case (addr)
            port2_phy_pkg::DIAG_OFFSET:        next_rdata = diag_word;
            port2_phy_pkg::DIAG_MIRROR_OFFSET: next_rdata = diag_word;
            port2_phy_pkg::CTRL_OFFSET:        next_rdata = ctrl_word;
            port2_phy_pkg::IRQ_STATUS_OFFSET:  next_rdata = {13'h0000, irq_status};
            port2_phy_pkg::IRQ_MASK_OFFSET:    next_rdata = {13'h0000, irq_mask};
            default:                           next_rdata = 16'h0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 16'h0000;
        end
    end

    // Event pulses: test end and wiring status changes
    always_comb begin
        irq_event = 3'h0;
        irq_event[port2_phy_pkg::IRQ_DONE]      = finish | fail;
        irq_event[port2_phy_pkg::IRQ_POLARITY]  = pol_s ^ pol_q;
        irq_event[port2_phy_pkg::IRQ_CROSSOVER] = cross_s ^ cross_q;
    end

    // Write one to clear a flag
    assign irq_clr = (wr && addr == port2_phy_pkg::IRQ_STATUS_OFFSET) ?
                     wdata[2:0] : 3'h0;

    // Sticky status flags
    sticky_bits #(
        .W(3)
    ) u_irq_status (
        .clock(clock),
        .rst  (rst),
        .set  (irq_event),
        .clr  (irq_clr),
        .q    (irq_status)
    );

    // Interrupt mask
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_mask <= port2_phy_pkg::IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask <= wdata[2:0];
        end
    end

    // Level interrupt, registered
    always_ff @(posedge clock) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // Checks on the bank behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Steps of a test
    sequence s_go_idle;
        (state == port2_phy_pkg::DIAG_IDLE) && go_req;
    endsequence

    sequence s_done_run;
        (state == port2_phy_pkg::DIAG_RUN) && done_rise;
    endsequence

    sequence s_read(logic [7:0] a);
        rd && (addr == a);
    endsequence

    property p_start;
        s_go_idle |=> diag_run && (state == port2_phy_pkg::DIAG_RUN);
    endproperty
    a_start: assert property (p_start) else $error("test did not start");

    property p_self_clear;
        s_done_run |=> !diag_run ##1 !diag_run[*2];
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("go not cleared");

    property p_go_visible;
        s_read(port2_phy_pkg::DIAG_OFFSET) |=>
            rdata[port2_phy_pkg::GO_BIT] == $past(diag_run);
    endproperty
    a_go_visible: assert property (p_go_visible) else $error("go bit wrong");

    property p_timeout;
        (state == port2_phy_pkg::DIAG_RUN) && tmo_hit && !done_rise |=>
            result == port2_phy_pkg::RESULT_FAILED && !diag_run;
    endproperty
    a_timeout: assert property (p_timeout) else $error("no failed code");

    property p_capture;
        s_done_run |=> result == $past(result_s) && count == $past(count_s);
    endproperty
    a_capture: assert property (p_capture) else $error("result not taken");

    property p_short;
        s_done_run |=> near_short == $past(short_s);
    endproperty
    a_short: assert property (p_short) else $error("short flag wrong");

    property p_mirror;
        s_read(port2_phy_pkg::DIAG_MIRROR_OFFSET) |=> rdata == $past(diag_word);
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror differs");

    property p_status;
        s_read(port2_phy_pkg::CTRL_OFFSET) |=>
            rdata[5:4] == {$past(pol_s), $past(cross_s)};
    endproperty
    a_status: assert property (p_status) else $error("wiring status wrong");

    property p_force;
        wr_ctrl |=> force_link == $past(wdata[port2_phy_pkg::FORCE_LINK_BIT]);
    endproperty
    a_force: assert property (p_force) else $error("force link wrong");

    property p_power;
        wr_ctrl |=> power_save_off == $past(wdata[port2_phy_pkg::POWER_SAVE_OFF_BIT]);
    endproperty
    a_power: assert property (p_power) else $error("power save wrong");

    property p_loop;
        wr_ctrl |=> near_end_loopback == $past(wdata[port2_phy_pkg::LOOPBACK_BIT]);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback wrong");

    property p_ro_stable;
        wr_diag && (state == port2_phy_pkg::DIAG_IDLE) |=>
            $stable(result) && $stable(count) && $stable(near_short);
    endproperty
    a_ro_stable: assert property (p_ro_stable) else $error("read-only changed");

    property p_reserved;
        s_read(port2_phy_pkg::CTRL_OFFSET) |=> rdata[15:6] == 10'h000 && !rdata[0];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule

// ==== xcvr_model.sv ====
/*
 * Behavioural transceiver that answers cable diagnostic runs.
 * Assumes the bench sets the cfg inputs before each run starts.
 */
`timescale 1ns/10ps
module xcvr_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Run setup from the bench
    input  wire logic [1:0] cfg_result,
    input  wire logic       cfg_short,
    input  wire logic [8:0] cfg_count,
    input  wire logic       cfg_hang,
    // Diagnostic handshake
    input  wire logic       diag_run,
    output logic            diag_done,
    output logic [1:0]      diag_result,
    output logic            diag_short,
    output logic [8:0]      diag_count
);
    int          cyc;   // Cycles spent in the current run
    logic [11:0] lines; // Result lines as one bundle

    assign {diag_result, diag_short, diag_count} = lines;

    // Lines settle at once, done follows six cycles later
    always @(posedge clock) begin
        if (rst) begin
            cyc       <= 0;
            diag_done <= 1'b0;
            lines     <= 12'h000;
        end else if (!diag_run) begin
            // Released lines wander so stale values cannot pass
            cyc       <= 0;
            diag_done <= 1'b0;
            lines     <= ~lines;
        end else begin
            cyc   <= cyc + 1;
            lines <= {cfg_result, cfg_short, cfg_count};
            if (cyc == 6 && !cfg_hang) begin
                diag_done <= 1'b1;
            end
        end
    end
endmodule

// ==== cable_diag_regs_test.sv ====
/*
 * Self-checking bench for the cable diagnostic register bank.
 * Assumes the design package is compiled first; timeout shortened to 20.
 */
`timescale 1ns/10ps
module cable_diag_regs_test;
    // Design and model wiring
    logic        clock;
    logic        rst;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        diag_run;
    logic        diag_done;
    logic [1:0]  diag_result;
    logic        diag_short;
    logic [8:0]  diag_count;
    logic        polarity_reversed;
    logic        crossover_state;
    logic        force_link;
    logic        power_save_off;
    logic        near_end_loopback;
    logic        irq;
    logic [1:0]  cfg_result;
    logic        cfg_short;
    logic [8:0]  cfg_count;
    logic        cfg_hang;
    // Bookkeeping
    logic        rd_prev;
    logic [15:0] expq[$];
    int          mismatches = 0;
    int          samples_checked = 0;

    cable_diag_regs #(.DIAG_TIMEOUT_CYCLES(20)) uut (.clock(clock), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .diag_run(diag_run), .diag_done(diag_done), .diag_result(diag_result),
        .diag_short(diag_short), .diag_count(diag_count),
        .polarity_reversed(polarity_reversed), .crossover_state(crossover_state),
        .force_link(force_link), .power_save_off(power_save_off),
        .near_end_loopback(near_end_loopback), .irq(irq));

    xcvr_model partner (.clock(clock), .rst(rst), .cfg_result(cfg_result),
        .cfg_short(cfg_short), .cfg_count(cfg_count), .cfg_hang(cfg_hang),
        .diag_run(diag_run), .diag_done(diag_done), .diag_result(diag_result),
        .diag_short(diag_short), .diag_count(diag_count));

    // Pseudo-random step
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One strobe cycle, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock);
    endtask

    // Read with the expected image noted first
    task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
        expq.push_back(e);
        bus(1'b0, a, 16'h0000);
    endtask

    // Read data only in the cycle after a read, zero otherwise
    always @(posedge clock) rd_prev <= rd;
    always @(negedge clock) begin
        if (rd_prev) begin
            check(rdata, expq.pop_front());
        end else if (!rst) begin
            check(rdata, 16'h0000);
        end
    end

    // Clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Watchdog
    initial begin
        #500000;
        mismatches++;
        test_done();
    end

    // Main sequence
    initial begin
        logic [7:0]  rnd;
        logic [15:0] w;
        logic [15:0] res;
        int          n;
        rnd = 8'h5A;
        res = 16'h0000;
        rst = 1'b1;
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        polarity_reversed = 1'b0;
        crossover_state = 1'b0;
        cfg_result = 2'h0;
        cfg_short = 1'b0;
        cfg_count = 9'h000;
        cfg_hang = 1'b0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // Values after reset, unmapped read
        rd_exp(8'h04, 16'h0000);
        rd_exp(8'h06, 16'h0004);
        rd_exp(8'h20, 16'h0000);
        rd_exp(8'h08, 16'h0000);
        check({13'h0000, force_link, power_save_off, near_end_loopback}, 16'h0002);
        $display("reset test done");
        // Control bits store, read-only and reserved bits ignore writes
        for (n = 0; n < 5; n++) begin
            rnd = lfsr(rnd);
            w = (n == 0) ? 16'hFFFF : {rnd, ~rnd};
            bus(1'b1, 8'h06, w);
            rd_exp(8'h06, {12'h000, w[3:1], 1'b0});
            check({13'h0000, force_link, power_save_off, near_end_loopback},
                  {13'h0000, w[3:1]});
        end
        $display("control test done");
        // Wiring status and interrupt mask and clear
        polarity_reversed <= 1'b1;
        crossover_state <= 1'b1;
        repeat (4) @(posedge clock);
        rd_exp(8'h06, {10'h000, 2'b11, w[3:1], 1'b0});
        rd_exp(8'h20, 16'h0006);
        check({15'h0000, irq}, 16'h0000);
        bus(1'b1, 8'h22, 16'h0004);
        // Registered outputs are read mid-cycle, once they have settled
        @(negedge clock);
        check({15'h0000, irq}, 16'h0001);
        @(posedge clock);
        bus(1'b1, 8'h20, 16'h0006);
        @(negedge clock);
        check({15'h0000, irq}, 16'h0000);
        @(posedge clock);
        bus(1'b1, 8'h22, 16'h0001);
        $display("status test done");
        // Every outcome code, go through both views, last one times out
        for (n = 0; n < 4; n++) begin
            rnd = lfsr(rnd);
            cfg_result <= n[1:0];
            cfg_short <= rnd[7];
            cfg_count <= {rnd[0], rnd};
            cfg_hang <= (n == 3);
            bus(1'b1, n[0] ? 8'h10 : 8'h04, 16'hFFFF);
            @(negedge clock);
            check({15'h0000, diag_run}, 16'h0001);
            @(posedge clock);
            rd_exp(8'h04, {1'b1, res[14:0]});
            for (int k = 0; k < 60 && diag_run === 1'b1; k++) @(posedge clock);
            @(negedge clock);
            check({15'h0000, diag_run}, 16'h0000);
            @(posedge clock);
            res = (n == 3) ? 16'h6000 : {1'b0, n[1:0], rnd[7], 3'b000, rnd[0], rnd};
            rd_exp(8'h04, res);
            rd_exp(8'h10, res);
            check({15'h0000, irq}, 16'h0001);
            bus(1'b1, 8'h20, 16'h0001);
            @(negedge clock);
            check({15'h0000, irq}, 16'h0000);
            @(posedge clock);
        end
        $display("diagnostic test done");
        test_done();
    end
endmodule
